// ---- core/ths_sup_map.vh ----
// Constants for the two-hand start supervisor
`ifndef THS_SUP_MAP_VH
`define THS_SUP_MAP_VH
// ----------------------------------------
// Timing
// ----------------------------------------
`define THS_CLK_HZ          20000000
`define THS_WINDOW_MS       200
`define THS_DEBOUNCE_US     10000
`define THS_HOLD_US         50000
// Cycle counts at the clock above, sized to the counter width
`define THS_WINDOW_CYC      24'h3D0900
`define THS_DEBOUNCE_CYC    24'h030D40
`define THS_HOLD_CYC        24'h0F4240
// ----------------------------------------
// Counter widths and reset values
// ----------------------------------------
`define THS_CNT_W           24
`define THS_CNT_ZERO        24'h000000
`define THS_CNT_ONE         24'h000001
`define THS_BIT_CLR         1'h0
`define THS_BIT_SET         1'h1
// ----------------------------------------
// Supervisor states, one-hot
// ----------------------------------------
`define THS_ST_W            5
`define THS_ST_IDLE         5'h01
`define THS_ST_FIRST        5'h02
`define THS_ST_HOLD         5'h04
`define THS_ST_RUN          5'h08
`define THS_ST_WAITOFF      5'h10
`endif

// ---- core/ths_debounce.v ----
// Synchroniser and debounce filter for one switch input
`timescale 1ns/1ps
`include "ths_sup_map.vh"
module ths_debounce
#(
	parameter CNT_W      = `THS_CNT_W,
	parameter [CNT_W-1:0] STABLE_CNT = `THS_CNT_ONE
)
(
	input  wire ref_clk,
	input  wire rst,
	input  wire rawIn,
	output wire cleanOut
);
	// ----------------------------------------
	// Storage
	// ----------------------------------------
	reg             syncA_ff;    // First sync stage, read only by syncB_ff
	reg             syncB_ff;    // Second sync stage
	reg             clean_ff;    // Filtered level
	reg [CNT_W-1:0] cnt_ff;      // Stability counter
	reg [CNT_W-1:0] nxt_cnt;
	reg             nxt_clean;

	assign cleanOut = clean_ff;

	// Next-value logic: level must differ for STABLE_CNT cycles to flip
	always @*
	begin
		nxt_cnt   = cnt_ff;
		nxt_clean = clean_ff;
		if (syncB_ff == clean_ff)
			nxt_cnt = {CNT_W{1'b0}};   // Bounce back resets the count
		else if (cnt_ff >= STABLE_CNT - `THS_CNT_ONE)
		begin
			nxt_clean = syncB_ff;
			nxt_cnt   = {CNT_W{1'b0}};
		end
		else
			nxt_cnt = cnt_ff + `THS_CNT_ONE;
	end

	// Registers
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			syncA_ff <= `THS_BIT_CLR;
			syncB_ff <= `THS_BIT_CLR;
			clean_ff <= `THS_BIT_CLR;
			cnt_ff   <= `THS_CNT_ZERO;
		end
		else
		begin
			syncA_ff <= rawIn;
			syncB_ff <= syncA_ff;
			clean_ff <= nxt_clean;
			cnt_ff   <= nxt_cnt;
		end
	end
endmodule // ths_debounce

// ---- core/ths_supervisor.v ----
// Two-hand start supervisor: timing window, hold, e-stop gating
`timescale 1ns/1ps
`include "ths_sup_map.vh"
// Notes on behaviour
// - Two start switches plus e-stop required
// - Second closure within 200 ms, any order
// - Late second closure: no cycle, error
// - Error self-clears on next good pair
// - Start inputs normally open, high means pressed
// - Either e-stop contact open blocks/ends start
module ths_supervisor
#(
	parameter CNT_W        = `THS_CNT_W,
	// Cycle counts for a 20 MHz system clock
	parameter [CNT_W-1:0] WINDOW_CYC   = `THS_WINDOW_CYC,   // 200 ms closure window
	parameter [CNT_W-1:0] DEBOUNCE_CYC = `THS_DEBOUNCE_CYC, // 10 ms contact settle time
	parameter [CNT_W-1:0] HOLD_CYC     = `THS_HOLD_CYC      // 50 ms hold before release
)
(
	input  wire ref_clk,
	input  wire rst,
	input  wire firstStartSwitch,        // High while contact closed
	input  wire secondStartSwitch,       // High while contact closed
	input  wire emergencyHaltLoopA,      // High while NC contact closed
	input  wire emergencyHaltLoopB,      // High while NC contact closed
	input  wire cycleDone,               // Weld cycle finished pulse
	output wire weldStart,               // One-cycle start pulse
	output wire weldActive,              // Level while cycle runs
	output wire handsOffPermitted,       // Switches may be released
	output wire twoHandTimingError,      // Error indication for display
	output wire emergencyHalt            // E-stop condition level
);
	// ----------------------------------------
	// Filtered inputs
	// ----------------------------------------
	wire [3:0] rawIn;     // Raw switch levels
	wire [3:0] cleanIn;   // Debounced levels

	assign rawIn = {emergencyHaltLoopB, emergencyHaltLoopA,
		secondStartSwitch, firstStartSwitch};

	// One filter per switch; bounce never looks like a release
	// Four counters cost area, but a shared one would let one contact hide another
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1)
		begin : gDeb
			ths_debounce #(
				.CNT_W      (CNT_W),
				.STABLE_CNT (DEBOUNCE_CYC)
			) uDeb (
				.ref_clk  (ref_clk),
				.rst      (rst),
				.rawIn    (rawIn[gi]),
				.cleanOut (cleanIn[gi])
			);
		end
	endgenerate

	// Closed contacts read high; the stop loops are normally closed
	wire pressA  = cleanIn[0];
	wire pressB  = cleanIn[1];
	wire bothOn  = pressA & pressB;
	wire anyOn   = pressA | pressB;
	wire halt    = ~(cleanIn[2] & cleanIn[3]);

	// ----------------------------------------
	// State and registers
	// ----------------------------------------
	reg [`THS_ST_W-1:0] state_ff;     // One-hot supervisor state
	reg [`THS_ST_W-1:0] nxt_state;
	// Timer is shared: FIRST and HOLD never run together
	reg [CNT_W-1:0]     tmr_ff;       // Window or hold timer
	reg [CNT_W-1:0]     nxt_tmr;
	reg                 err_ff;       // Timing error indication
	reg                 nxt_err;
	reg                 start_ff;     // Start pulse
	reg                 nxt_start;
	reg                 release_ff;   // Hands-off indication
	reg                 nxt_release;
	reg                 active_ff;    // Cycle running
	reg                 nxt_active;
	reg                 halt_ff;      // Registered e-stop level

	// ----------------------------------------
	// One-hot state codes
	// ----------------------------------------
	// Codes live in the constants header; one bit per state
	localparam [`THS_ST_W-1:0] ST_IDLE    = `THS_ST_IDLE;    // Waiting for a first closure
	localparam [`THS_ST_W-1:0] ST_FIRST   = `THS_ST_FIRST;   // One switch closed, window open
	localparam [`THS_ST_W-1:0] ST_HOLD    = `THS_ST_HOLD;    // Both closed, holding before release
	localparam [`THS_ST_W-1:0] ST_RUN     = `THS_ST_RUN;     // Weld cycle running
	localparam [`THS_ST_W-1:0] ST_WAITOFF = `THS_ST_WAITOFF; // Waiting for both hands off

	assign weldStart          = start_ff;
	assign weldActive         = active_ff;
	assign handsOffPermitted  = release_ff;
	assign twoHandTimingError = err_ff;
	assign emergencyHalt      = halt_ff;

	// ----------------------------------------
	// Supervisor next-state logic
	// ----------------------------------------
	// Outputs are decided here and registered below, so every
	// indication leaves the block from a flip-flop
	always @*
	begin
		nxt_state   = state_ff;
		nxt_tmr     = tmr_ff;
		nxt_err     = err_ff;
		nxt_start   = `THS_BIT_CLR;
		nxt_release = `THS_BIT_CLR;
		nxt_active  = active_ff;
		case (state_ff)
			ST_IDLE:
			begin
				// Timer parked at zero so FIRST always opens a fresh window
				nxt_tmr = `THS_CNT_ZERO;
				// Both closing in one cycle is zero skew
				if (halt)
					nxt_state = ST_IDLE;
				else if (bothOn)
				begin
					nxt_state = ST_HOLD;
					nxt_err   = `THS_BIT_CLR;
				end
				else if (anyOn)
					nxt_state = ST_FIRST;
			end
			ST_FIRST:
			begin
				// Counts cycles since the first filtered closure
				nxt_tmr = tmr_ff + `THS_CNT_ONE;
				if (halt || !anyOn)
					nxt_state = ST_IDLE;
				else if (bothOn)
				begin
					// Tested ahead of the timeout, so a pair exactly at
					// the window edge still counts as in time
					nxt_state = ST_HOLD;
					nxt_err   = `THS_BIT_CLR;
					nxt_tmr   = `THS_CNT_ZERO;
				end
				else if (tmr_ff >= WINDOW_CYC - `THS_CNT_ONE)
				begin
					// Error is only set here, so it never meets a clear
					nxt_state = ST_WAITOFF;
					nxt_err   = `THS_BIT_SET;
				end
			end
			ST_HOLD:
			begin
				// Early release or e-stop aborts the start
				nxt_tmr = tmr_ff + `THS_CNT_ONE;
				if (halt)
					nxt_state = ST_WAITOFF;
				else if (!bothOn)
					nxt_state = ST_WAITOFF;
				else if (tmr_ff >= HOLD_CYC - `THS_CNT_ONE)
				begin
					nxt_state   = ST_RUN;
					nxt_start   = `THS_BIT_SET;
					nxt_active  = `THS_BIT_SET;
					nxt_release = `THS_BIT_SET;
				end
			end
			ST_RUN:
			begin
				// Release indication tracks the run and drops with it
				nxt_release = `THS_BIT_SET;
				if (halt || cycleDone)
				begin
					nxt_state   = ST_WAITOFF;
					nxt_active  = `THS_BIT_CLR;
					nxt_release = `THS_BIT_CLR;
				end
			end
			ST_WAITOFF:
			begin
				// New attempt needs both hands off first; a held switch
				// must not open a window that began before the release
				nxt_active = `THS_BIT_CLR;
				nxt_tmr    = `THS_CNT_ZERO;
				if (!anyOn)
					nxt_state = ST_IDLE;
			end
			default:
			begin
				// Illegal one-hot code: recover to a safe idle
				nxt_state  = ST_IDLE;
				nxt_active = `THS_BIT_CLR;
				nxt_tmr    = `THS_CNT_ZERO;
			end
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Halt resets raised: the stop loops read open until they debounce
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			state_ff   <= ST_IDLE;
			tmr_ff     <= `THS_CNT_ZERO;
			err_ff     <= `THS_BIT_CLR;
			start_ff   <= `THS_BIT_CLR;
			release_ff <= `THS_BIT_CLR;
			active_ff  <= `THS_BIT_CLR;
			halt_ff    <= `THS_BIT_SET;
		end
		else
		begin
			state_ff   <= nxt_state;
			tmr_ff     <= nxt_tmr;
			err_ff     <= nxt_err;
			start_ff   <= nxt_start;
			release_ff <= nxt_release;
			active_ff  <= nxt_active;
			halt_ff    <= halt;
		end
	end
endmodule // ths_supervisor

// ---- verification/ths_sup_chk.sv ----
// Port checker for the two-hand start supervisor
`timescale 1ns/1ps
module ths_sup_chk
(
	input wire ref_clk,
	input wire rst,
	input wire firstStartSwitch,
	input wire secondStartSwitch,
	input wire emergencyHaltLoopA,
	input wire cycleDone,
	input wire weldStart,
	input wire weldActive,
	input wire handsOffPermitted,
	input wire twoHandTimingError,
	input wire emergencyHalt
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// ----------------------------------------
	// Start and run relations
	// ----------------------------------------
	a_start_one_cyc: assert property (weldStart |=> !weldStart) else $error("start pulse too long");
	a_start_both_on: assert property (weldStart |-> firstStartSwitch && secondStartSwitch)
		else $error("start without both");
	a_start_no_halt: assert property (weldStart |-> !emergencyHalt) else $error("start in halt");
	a_start_no_err: assert property (weldStart |-> !twoHandTimingError) else $error("start with error");
	a_rise_by_start: assert property ($rose(weldActive) |-> weldStart) else $error("run without start");
	a_release_pair: assert property (weldActive == handsOffPermitted) else $error("release differs");
	a_halt_ends_run: assert property (emergencyHalt |-> ##[0:1] !weldActive) else $error("run in halt");
	a_halt_filtered: assert property ((!emergencyHaltLoopA)[*8] |-> emergencyHalt)
		else $error("open loop unseen");
	a_done_ends_run: assert property (cycleDone |=> !weldActive) else $error("run after done");
	// Main scenarios reached
	c_start: cover property (weldStart);
	c_error: cover property ($rose(twoHandTimingError));
	c_halt_run: cover property (weldActive ##1 emergencyHalt);
endmodule // ths_sup_chk
bind ths_supervisor ths_sup_chk chk_u (.ref_clk(ref_clk), .rst(rst), .firstStartSwitch(firstStartSwitch),
	.secondStartSwitch(secondStartSwitch), .emergencyHaltLoopA(emergencyHaltLoopA), .cycleDone(cycleDone),
	.weldStart(weldStart), .weldActive(weldActive), .handsOffPermitted(handsOffPermitted),
	.twoHandTimingError(twoHandTimingError), .emergencyHalt(emergencyHalt));

// ---- verification/ths_operator.sv ----
// Operator model: bouncing push-buttons and bounce-free e-stop contacts
`timescale 1ns/1ps
module ths_operator
(
	input  wire ref_clk,
	input  wire pressA,
	input  wire pressB,
	input  wire stopA,
	input  wire stopB,
	output wire firstStartSwitch,
	output wire secondStartSwitch,
	output wire emergencyHaltLoopA,
	output wire emergencyHaltLoopB
);
	reg [2:0] bncA_ff; // Cycles since press, saturating
	reg [2:0] bncB_ff;
	// One-cycle contact chatter just after each press
	always @(posedge ref_clk)
	begin
		bncA_ff <= pressA ? bncA_ff + {2'h0, bncA_ff != 3'h4} : 3'h0;
		bncB_ff <= pressB ? bncB_ff + {2'h0, bncB_ff != 3'h4} : 3'h0;
	end
	// Open contact reads low, pressed start reads high
	assign firstStartSwitch   = pressA & (bncA_ff != 3'h1);
	assign secondStartSwitch  = pressB & (bncB_ff != 3'h1);
	assign emergencyHaltLoopA = !stopA;
	assign emergencyHaltLoopB = !stopB;
endmodule // ths_operator

// ---- verification/ths_supervisor_tb.sv ----
// Self-checking bench for the two-hand start supervisor
`timescale 1ns/1ps
module ths_supervisor_tb;
	reg     ref_clk = 0, rst = 1, pressA = 0, pressB = 0, stopA = 0, stopB = 0, cycleDone = 0;
	wire    swA, swB, loopA, loopB, weldStart, weldActive, hop, err, halt;
	integer n_fail = 0, num_checks = 0, seed = 43, nStart = 0;
	reg     expErr = 0; // Model of the sticky error
	ths_operator op_u (.ref_clk(ref_clk), .pressA(pressA), .pressB(pressB), .stopA(stopA), .stopB(stopB),
		.firstStartSwitch(swA), .secondStartSwitch(swB), .emergencyHaltLoopA(loopA), .emergencyHaltLoopB(loopB));
	// Short counts keep the run brief: window 40, debounce 3, hold 10
	ths_supervisor #(.WINDOW_CYC(24'h000028), .DEBOUNCE_CYC(24'h000003), .HOLD_CYC(24'h00000A)) dut_u
		(.ref_clk(ref_clk), .rst(rst), .firstStartSwitch(swA), .secondStartSwitch(swB),
		.emergencyHaltLoopA(loopA), .emergencyHaltLoopB(loopB), .cycleDone(cycleDone), .weldStart(weldStart),
		.weldActive(weldActive), .handsOffPermitted(hop), .twoHandTimingError(err), .emergencyHalt(halt));
	initial forever #25 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (weldStart === 1'h1) nStart = nStart + 1;
	task check(input string name, input logic seen, input logic exp);
	begin
		num_checks = num_checks + 1;
		if (seen !== exp)
		begin
			n_fail = n_fail + 1;
			$display("CHECK FAILED %0s expected %b seen %b", name, exp, seen);
		end
	end
	endtask
	task cyc(input integer n);
		repeat (n) @(negedge ref_clk);
	endtask
	task end_of_test;
	begin
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
	endtask
	// One attempt: order, second used, skew, early release
	task attempt(input integer ord, input integer two, input integer g, input integer early);
		reg expStart;
	begin
		nStart = 0;
		expStart = two && !early && g <= 40 && !stopA;
		if (two && !stopA) expErr = (g > 40);
		if (ord) pressB = 1; else pressA = 1;
		cyc(g);
		if (two) begin pressA = 1; pressB = 1; end
		cyc(early ? 6 : 40);
		pressA = 0;
		pressB = 0;
		cycleDone = 1;
		cyc(1);
		cycleDone = 0;
		cyc(20);
		check("start", nStart == 1, expStart);
		check("error", err, expErr);
		check("active", weldActive, 1'h0);
		check("release", hop, 1'h0);
		$display("attempt skew %0d done", g);
	end
	endtask
	initial
	begin
		cyc(8);
		rst = 0;
		cyc(10);
		attempt(0, 1, $unsigned($random(seed)) % 31, 0);
		attempt(1, 1, $unsigned($random(seed)) % 31, 0);
		attempt(0, 1, 0, 0);
		attempt(0, 1, 60, 0);
		attempt(1, 1, $unsigned($random(seed)) % 31, 0);
		attempt(0, 0, 5, 1);
		attempt(0, 1, 5, 1);
		stopA = 1;
		attempt(0, 1, 5, 0);
		stopA = 0;
		cyc(10);
		// Halt in mid-run drops the cycle
		pressA = 1;
		pressB = 1;
		cyc(25);
		check("active", weldActive, 1'h1);
		check("release", hop, 1'h1);
		stopB = 1;
		cyc(10);
		check("active", weldActive, 1'h0);
		check("halt", halt, 1'h1);
		check("release", hop, 1'h0);
		$display("halt test done");
		end_of_test;
	end
	// Watchdog well beyond the expected run
	initial
	begin
		#(4000 * 50);
		n_fail = n_fail + 1;
		end_of_test;
	end
endmodule // ths_supervisor_tb
